/* File: common/homing_pkg.sv */
// Constants, register map and state codes of the homing sequencer.
// Assumes a 250 MHz core clock; speeds are held in 0.01 r/min units.
package homing_pkg;
	// Clock and time bases
	localparam int CLK_PERIOD_NS = 4;
	localparam int TENTH_MS_NS   = 100000;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_TENTH = TENTH_MS_NS / CLK_PERIOD_NS;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

	// Speed scale: ramp times refer to 2000.00 r/min
	localparam logic [19:0] FULL_SCALE_SPEED = 20'h30D40;
	localparam logic [19:0] HOMING_SPEED_RST = 20'h0C350;
	localparam logic [19:0] CREEP_SPEED_RST  = 20'h01388;
	localparam logic [19:0] RAMP_T1_RST      = 20'h003E8;
	localparam logic [19:0] RAMP_T2_RST      = 20'h01388;
	localparam logic [19:0] RAMP_TIME_MAX    = 20'hF423F;

	// Limits of the settings
	localparam logic [13:0] DETECT_TIME_MAX  = 14'h2710;
	localparam logic [8:0]  STOP_TORQ_MAX    = 9'h064;
	localparam logic [8:0]  ABORT_TORQ_MAX   = 9'h12C;
	localparam logic [8:0]  TORQ_FREE        = 9'h12C;
	localparam logic [30:0] SHIFT_AMOUNT_RST = 31'h000003E8;
	localparam logic [30:0] SHIFT_MAX        = 31'h77359400;
	localparam logic signed [31:0] COORD_MAX = 32'sh77359400;
	localparam logic [19:0] INDEX_OFFS_MAX   = 20'hFFFFF;

	// Shift reference codes
	localparam logic [2:0] REF_LS   = 3'h0;
	localparam logic [2:0] REF_Z    = 3'h1;
	localparam logic [2:0] REF_POT  = 3'h2;
	localparam logic [2:0] REF_NOT  = 3'h3;
	localparam logic [2:0] REF_INT  = 3'h4;
	localparam logic [2:0] REF_STOP = 3'h5;

	// Deceleration-start codes
	localparam logic [1:0] DEC_LS  = 2'h0;
	localparam logic [1:0] DEC_POT = 2'h1;
	localparam logic [1:0] DEC_NOT = 2'h2;

	// Register byte addresses
	localparam logic [6:0] A_CTRL   = 7'h00;
	localparam logic [6:0] A_HSPEED = 7'h04;
	localparam logic [6:0] A_CSPEED = 7'h08;
	localparam logic [6:0] A_SHIFT  = 7'h0C;
	localparam logic [6:0] A_COORD  = 7'h10;
	localparam logic [6:0] A_RANGE  = 7'h14;
	localparam logic [6:0] A_DTIME  = 7'h18;
	localparam logic [6:0] A_TORQ   = 7'h1C;
	localparam logic [6:0] A_ZOFFS  = 7'h20;
	localparam logic [6:0] A_ACC1   = 7'h24;
	localparam logic [6:0] A_DEC1   = 7'h28;
	localparam logic [6:0] A_ACC2   = 7'h2C;
	localparam logic [6:0] A_DEC2   = 7'h30;
	localparam logic [6:0] A_STAT   = 7'h38;
	localparam logic [6:0] A_MASK   = 7'h3C;
	localparam logic [6:0] A_POS    = 7'h40;
	localparam logic [6:0] A_STATE  = 7'h44;

	// Control word fields
	localparam int F_REF  = 0;
	localparam int F_DEC  = 4;
	localparam int F_EDGE = 8;
	localparam int F_SDIR = 9;
	localparam int F_PDIR = 10;
	localparam int F_OTR  = 11;
	localparam int F_RSET = 12;
	localparam int F_TQA  = 16;
	localparam logic [12:0] CTRL_RST = 13'h0001;

	// Interrupt status bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_REV   = 2;
	localparam int IRQ_W     = 3;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_SEARCH = 6'h02,
		ST_CREEP  = 6'h04,
		ST_SHIFT  = 6'h08,
		ST_SETTLE = 6'h10,
		ST_ABORT  = 6'h20
	} hstate_t;
endpackage

/* File: core/velocity_ramp.sv */
// Signed velocity ramp stepping one 0.01 r/min unit at a time, or straight to target for a zero period.
// Assumes the ramp periods stay steady while a ramp is running.
`timescale 1ns/1ps
`default_nettype none
module velocity_ramp
	import homing_pkg::*;
#(
	parameter int VW = 21
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Target and ramp periods in clock cycles
	input  wire logic signed [VW-1:0] target,
	input  wire logic [39:0]          acc_period,
	input  wire logic [39:0]          dec_period,
	// Present velocity
	output logic signed [VW-1:0]      vel_ff
);
	initial begin
		if (VW < 21)
			$error("velocity_ramp: VW too narrow for full scale");
	end

	logic [39:0] acc_ff;   // Fractional step accumulator
	logic        slowing;  // Step takes magnitude toward zero
	logic [39:0] period;   // Period of the ramp in use

	always_comb begin
		slowing = (vel_ff > 0 && target < vel_ff) ||
			(vel_ff < 0 && target > vel_ff);
		period = slowing ? dec_period : acc_period;
	end

	// Fraction is dropped on each step; fast ramps cap at one step every two cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= 40'h0;
			vel_ff <= '0;
		end else if (vel_ff == target) begin
			acc_ff <= 40'h0;
		end else if (period == 40'h0) begin
			vel_ff <= target;
			acc_ff <= 40'h0;
		end else if (acc_ff >= period) begin
			acc_ff <= 40'h0;
			vel_ff <= (target > vel_ff) ? vel_ff + 1'b1 : vel_ff - 1'b1;
		end else begin
			acc_ff <= acc_ff + {20'h0, FULL_SCALE_SPEED};
		end
	end
endmodule
`default_nettype wire

/* File: core/servo_homing_sequencer.sv */
// Homing sequencer: search, creep, shift, settle, with overtravel care.
// Assumes sensor inputs and encoder steps are synchronous to CLOCK.
//
// How it works
// - Stopper time and torque only for stopper
// - Stopper contact after standstill time, 0..10000 ms
// - Stopper torque clamp 0..100 percent
// - Reaction zero: reverse on first overtravel
// - Reaction one: abort and controlled stop
// - Abort stop uses third torque limit
// - Index pulse shifted by 20-bit offset
// - Ramp time means 0 to 2000 r/min
// - Two ramp sets, 100.0 and 500.0 ms
// - Start edge moves start direction, homing speed with index reference, creep speed otherwise
// - Decel signal: post direction, or away from a limit used as decel, creep speed
// - Index then shift travel, stop, complete
// - Early overtravel reverses search direction
// - Homing 500.00, creep 50.00 r/min defaults
// - Reference codes 0..5, default index
// - Completion loads position with home coordinate
// - Complete within range; zero means always
`timescale 1ns/1ps
`default_nettype none
module servo_homing_sequencer
	import homing_pkg::*;
#(
	parameter int MS_CYCLES = CYC_PER_MS
) (
	// Clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RESETN,
	// Register port
	input  wire logic [6:0]         ADDR,
	input  wire logic [31:0]        WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic [31:0]             RDATA,
	// Host command and sensors
	input  wire logic               HOMING_START_CMD,
	input  wire logic               POSITIVE_TRAVEL_LIMIT,
	input  wire logic               NEGATIVE_TRAVEL_LIMIT,
	input  wire logic               HOME_LIMIT_SWITCH,
	input  wire logic               INTERRUPT_INPUT,
	input  wire logic               ENCODER_INDEX,
	// Encoder motion feedback
	input  wire logic               POS_STEP,
	input  wire logic               POS_FWD,
	// Motion outputs
	output logic signed [20:0]      SPEED_CMD,
	output logic [8:0]              TORQUE_LIMIT,
	output logic                    HOME_DONE,
	output logic                    BUSY,
	output logic                    IRQ
);
	initial begin
		if (MS_CYCLES < 1)
			$error("servo_homing_sequencer: MS_CYCLES below one");
	end

	// Settings
	logic [12:0]        ctrl_ff;       // Selects and directions
	logic [19:0]        hspeed_ff;     // Homing speed
	logic [19:0]        cspeed_ff;     // Creep speed
	logic [30:0]        shift_ff;      // Home shift amount
	logic signed [31:0] coord_ff;      // Home coordinate
	logic [30:0]        range_ff;      // Completion range
	logic [13:0]        dtime_ff;      // Stopper time, ms
	logic [8:0]         stq_ff;        // Stopper torque
	logic [8:0]         atq_ff;        // Abort torque
	logic [19:0]        zoffs_ff;      // Index offset
	logic [19:0]        ramp_ff [4];   // acc1 dec1 acc2 dec2
	logic [IRQ_W-1:0]   stat_ff;       // Sticky events
	logic [IRQ_W-1:0]   mask_ff;       // Event enables
	// Sequencer state
	hstate_t            state_ff;
	logic               dir_ff;        // 1 = forward
	logic               rev_done_ff;   // One reversal spent
	logic               homed_ff;
	logic [30:0]        trav_ff;       // Shift steps so far
	logic signed [31:0] pos_ff;        // Current position
	logic               start_q_ff, ls_q_ff, z_q_ff, int_q_ff;
	logic               zarm_ff;       // Offset count running
	logic [19:0]        zcnt_ff;
	logic               zeff_ff;       // Shifted index pulse
	logic [31:0]        tick_ff;       // Cycles within a ms
	logic [13:0]        still_ff;      // Standstill ms
	logic signed [20:0] vel;

	// Field views
	logic [2:0] ref_sel;
	logic [1:0] dec_sel;
	logic       ramp2, start_rise, ls_evt, decel_evt, ref_evt;
	logic       ot_hit, ot_act, vel_zero;
	logic [IRQ_W-1:0] evt;
	assign ref_sel   = ctrl_ff[F_REF +: 3];
	assign dec_sel   = ctrl_ff[F_DEC +: 2];
	assign ramp2     = ctrl_ff[F_RSET];
	assign vel_zero  = (vel == '0);
	assign start_rise = HOMING_START_CMD & ~start_q_ff;
	assign ls_evt = ctrl_ff[F_EDGE] ? (ls_q_ff & ~HOME_LIMIT_SWITCH)
		: (HOME_LIMIT_SWITCH & ~ls_q_ff);

	// Deceleration-start detection
	always_comb begin
		case (dec_sel)
			DEC_LS:  decel_evt = ls_evt;
			DEC_POT: decel_evt = POSITIVE_TRAVEL_LIMIT;
			DEC_NOT: decel_evt = NEGATIVE_TRAVEL_LIMIT;
			default: decel_evt = 1'b0;
		endcase
	end

	always_comb begin
		case (ref_sel)
			REF_LS:   ref_evt = ls_evt;
			REF_Z:    ref_evt = zeff_ff;
			REF_POT:  ref_evt = POSITIVE_TRAVEL_LIMIT;
			REF_NOT:  ref_evt = NEGATIVE_TRAVEL_LIMIT;
			REF_INT:  ref_evt = INTERRUPT_INPUT & ~int_q_ff;
			REF_STOP: ref_evt = (still_ff >= dtime_ff);
			default:  ref_evt = 1'b0;
		endcase
	end

	// Overtravel ahead, unless that limit is the chosen signal
	always_comb begin
		ot_hit = dir_ff ? POSITIVE_TRAVEL_LIMIT : NEGATIVE_TRAVEL_LIMIT;
		if ((dir_ff && (ref_sel == REF_POT || dec_sel == DEC_POT)) ||
			(!dir_ff && (ref_sel == REF_NOT || dec_sel == DEC_NOT)))
			ot_hit = 1'b0;
		ot_act = ot_hit && ((state_ff == ST_SEARCH && !decel_evt) ||
			(state_ff == ST_CREEP && !ref_evt));
	end

	// Input history for edge detection
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			start_q_ff <= 1'b0;
			ls_q_ff    <= 1'b0;
			z_q_ff     <= 1'b0;
			int_q_ff   <= 1'b0;
		end else begin
			start_q_ff <= HOMING_START_CMD;
			ls_q_ff    <= HOME_LIMIT_SWITCH;
			z_q_ff     <= ENCODER_INDEX;
			int_q_ff   <= INTERRUPT_INPUT;
		end
	end

	// Settings writes, clamped to their ranges
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_ff    <= CTRL_RST;
			hspeed_ff  <= HOMING_SPEED_RST;
			cspeed_ff  <= CREEP_SPEED_RST;
			shift_ff   <= SHIFT_AMOUNT_RST;
			coord_ff   <= '0;
			range_ff   <= '0;
			dtime_ff   <= '0;
			stq_ff     <= '0;
			atq_ff     <= '0;
			zoffs_ff   <= '0;
			ramp_ff[0] <= RAMP_T1_RST;
			ramp_ff[1] <= RAMP_T1_RST;
			ramp_ff[2] <= RAMP_T2_RST;
			ramp_ff[3] <= RAMP_T2_RST;
			mask_ff    <= '0;
		end else if (WR) begin
			case (ADDR)
				A_CTRL:   ctrl_ff <= WDATA[12:0];
				A_HSPEED: hspeed_ff <= WDATA[19:0];
				A_CSPEED: cspeed_ff <= WDATA[19:0];
				A_SHIFT:  shift_ff <= (WDATA[30:0] > SHIFT_MAX) ?
					SHIFT_MAX : WDATA[30:0];
				A_COORD:  coord_ff <= ($signed(WDATA) > COORD_MAX) ?
					COORD_MAX : ($signed(WDATA) < -COORD_MAX) ?
					-COORD_MAX : $signed(WDATA);
				A_RANGE:  range_ff <= (WDATA[30:0] > SHIFT_MAX) ?
					SHIFT_MAX : WDATA[30:0];
				A_DTIME:  dtime_ff <= (WDATA[13:0] > DETECT_TIME_MAX ||
					|WDATA[31:14]) ? DETECT_TIME_MAX : WDATA[13:0];
				A_TORQ: begin
					stq_ff <= (WDATA[8:0] > STOP_TORQ_MAX) ?
						STOP_TORQ_MAX : WDATA[8:0];
					atq_ff <= (WDATA[F_TQA +: 9] > ABORT_TORQ_MAX) ?
						ABORT_TORQ_MAX : WDATA[F_TQA +: 9];
				end
				A_ZOFFS:  zoffs_ff <= WDATA[19:0];
				A_ACC1, A_DEC1, A_ACC2, A_DEC2:
					ramp_ff[2'((ADDR - A_ACC1) >> 2)] <=
						(WDATA[19:0] > RAMP_TIME_MAX) ?
						RAMP_TIME_MAX : WDATA[19:0];
				A_MASK:   mask_ff <= WDATA[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky events; a new event wins over a write-one clear
	assign evt[IRQ_DONE]  = (state_ff == ST_SETTLE) && vel_zero;
	assign evt[IRQ_ABORT] = ot_act && ctrl_ff[F_OTR];
	assign evt[IRQ_REV]   = ot_act && !ctrl_ff[F_OTR] && !rev_done_ff;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			stat_ff <= '0;
		else if (WR && ADDR == A_STAT)
			stat_ff <= (stat_ff & ~WDATA[IRQ_W-1:0]) | evt;
		else
			stat_ff <= stat_ff | evt;
	end

	// Read data, valid the cycle after RD; unmapped reads zero
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			RDATA <= '0;
		else if (RD) begin
			case (ADDR)
				A_CTRL:   RDATA <= {19'h0, ctrl_ff};
				A_HSPEED: RDATA <= {12'h0, hspeed_ff};
				A_CSPEED: RDATA <= {12'h0, cspeed_ff};
				A_SHIFT:  RDATA <= {1'b0, shift_ff};
				A_COORD:  RDATA <= coord_ff;
				A_RANGE:  RDATA <= {1'b0, range_ff};
				A_DTIME:  RDATA <= {18'h0, dtime_ff};
				A_TORQ:   RDATA <= {7'h0, atq_ff, 7'h0, stq_ff};
				A_ZOFFS:  RDATA <= {12'h0, zoffs_ff};
				A_ACC1, A_DEC1, A_ACC2, A_DEC2:
					RDATA <= {12'h0, ramp_ff[2'((ADDR - A_ACC1) >> 2)]};
				A_STAT:   RDATA <= {29'h0, stat_ff};
				A_MASK:   RDATA <= {29'h0, mask_ff};
				A_POS:    RDATA <= pos_ff;
				A_STATE:  RDATA <= {24'h0, homed_ff, 1'b0, state_ff};
				default:  RDATA <= '0;
			endcase
		end else
			RDATA <= '0;
	end

	// Index pulse delayed by offset steps past the raw edge
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			zarm_ff <= 1'b0;
			zcnt_ff <= '0;
			zeff_ff <= 1'b0;
		end else begin
			zeff_ff <= 1'b0;
			if (ENCODER_INDEX && !z_q_ff && !zarm_ff) begin
				zeff_ff <= (zoffs_ff == '0);
				zarm_ff <= (zoffs_ff != '0);
				zcnt_ff <= '0;
			end else if (zarm_ff && POS_STEP) begin
				zcnt_ff <= zcnt_ff + 1'b1;
				if (zcnt_ff + 1'b1 == zoffs_ff) begin
					zeff_ff <= 1'b1;
					zarm_ff <= 1'b0;
				end
			end
		end
	end

	// Standstill timer in ms while creeping
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tick_ff  <= '0;
			still_ff <= '0;
		end else if (state_ff != ST_CREEP || POS_STEP) begin
			tick_ff  <= '0;
			still_ff <= '0;
		end else if (tick_ff == 32'(MS_CYCLES - 1)) begin
			tick_ff  <= '0;
			if (still_ff != DETECT_TIME_MAX)
				still_ff <= still_ff + 1'b1;
		end else
			tick_ff <= tick_ff + 1'b1;
	end

	// Sequencer
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff    <= ST_IDLE;
			dir_ff      <= 1'b1;
			rev_done_ff <= 1'b0;
			trav_ff     <= '0;
		end else begin
			case (state_ff)
				ST_IDLE: if (start_rise) begin
					dir_ff      <= ~ctrl_ff[F_SDIR];
					rev_done_ff <= 1'b0;
					state_ff    <= (ref_sel == REF_Z) ? ST_SEARCH : ST_CREEP;
				end
				ST_SEARCH, ST_CREEP:
					if (state_ff == ST_SEARCH && decel_evt) begin
						dir_ff <= (dec_sel == DEC_POT) ? 1'b0 :
							(dec_sel == DEC_NOT) ? 1'b1 : ~ctrl_ff[F_PDIR];
						state_ff <= ST_CREEP;
					end else if (state_ff == ST_CREEP && ref_evt) begin
						trav_ff  <= '0;
						state_ff <= ST_SHIFT;
					end else if (ot_act) begin
						if (ctrl_ff[F_OTR] || rev_done_ff)
							state_ff <= ST_ABORT;
						else begin
							dir_ff      <= ~dir_ff;
							rev_done_ff <= 1'b1;
						end
					end
				ST_SHIFT: if (trav_ff >= shift_ff)
					state_ff <= ST_SETTLE;
				else if (POS_STEP)
					trav_ff <= trav_ff + 1'b1;
				ST_SETTLE, ST_ABORT: if (vel_zero)
					state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Position counter; completion load takes priority
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			pos_ff <= '0;
		else if (evt[IRQ_DONE])
			pos_ff <= coord_ff;
		else if (POS_STEP)
			pos_ff <= POS_FWD ? pos_ff + 1 : pos_ff - 1;
	end

	// Homed flag and completion output
	logic signed [32:0] pos_err;
	logic        [32:0] pos_abs;
	assign pos_err = 33'(pos_ff) - 33'(coord_ff);
	assign pos_abs = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			homed_ff  <= 1'b0;
			HOME_DONE <= 1'b0;
			BUSY      <= 1'b0;
		end else begin
			// New start or abort drops completion
			if ((state_ff == ST_IDLE && start_rise) || evt[IRQ_ABORT])
				homed_ff <= 1'b0;
			else if (evt[IRQ_DONE])
				homed_ff <= 1'b1;
			HOME_DONE <= homed_ff && (range_ff == '0 ||
				pos_abs <= {2'b0, range_ff});
			BUSY <= (state_ff != ST_IDLE);
		end
	end

	// Target velocity per state
	logic signed [20:0] target;
	logic        [19:0] tgt_mag;
	always_comb begin
		case (state_ff)
			ST_SEARCH:          tgt_mag = hspeed_ff;
			ST_CREEP, ST_SHIFT: tgt_mag = cspeed_ff;
			default:            tgt_mag = '0;
		endcase
		target = dir_ff ? $signed({1'b0, tgt_mag}) :
			-$signed({1'b0, tgt_mag});
	end

	// Ramp periods from the selected set
	logic [39:0] acc_per, dec_per;
	assign acc_per = 40'(ramp_ff[ramp2 ? 2 : 0]) * 40'(CYC_PER_TENTH);
	assign dec_per = 40'(ramp_ff[ramp2 ? 3 : 1]) * 40'(CYC_PER_TENTH);

	velocity_ramp #(
		.VW         (21)
	) u_ramp (
		.clk        (CLOCK),
		.rst_n      (RESETN),
		.target     (target),
		.acc_period (acc_per),
		.dec_period (dec_per),
		.vel_ff     (vel)
	);

	// Registered motion outputs and interrupt
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			SPEED_CMD    <= '0;
			TORQUE_LIMIT <= TORQ_FREE;
			IRQ          <= 1'b0;
		end else begin
			SPEED_CMD <= vel;
			IRQ       <= |(stat_ff & mask_ff);
			if (state_ff == ST_ABORT)
				TORQUE_LIMIT <= atq_ff;
			else if (state_ff == ST_CREEP && ref_sel == REF_STOP)
				TORQUE_LIMIT <= stq_ff;
			else
				TORQUE_LIMIT <= TORQ_FREE;
		end
	end

	// Checks
	sequence s_idle_start;
		state_ff == ST_IDLE && start_rise;
	endsequence
	sequence s_search_decel;
		state_ff == ST_SEARCH && decel_evt;
	endsequence
	sequence s_creep_ref;
		state_ff == ST_CREEP && ref_evt;
	endsequence

	AST_START_GO: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_idle_start |=> (state_ff != ST_IDLE) ##1 BUSY && !HOME_DONE)
		else $error("start edge did not launch homing");
	AST_BUSY_IGNORE: assert property (@(posedge CLOCK)
		disable iff (!RESETN)
		state_ff == ST_SEARCH && start_rise && !decel_evt && !ot_act
		|=> state_ff == ST_SEARCH)
		else $error("start edge disturbed a running sequence");
	AST_DECEL_CREEP: assert property (@(posedge CLOCK)
		disable iff (!RESETN) s_search_decel |=> state_ff == ST_CREEP)
		else $error("decel signal did not enter creep");
	AST_REF_SHIFT: assert property (@(posedge CLOCK)
		disable iff (!RESETN) s_creep_ref |=> state_ff == ST_SHIFT)
		else $error("reference did not start shift travel");
	AST_OT_REVERSE: assert property (@(posedge CLOCK)
		disable iff (!RESETN)
		ot_act && !ctrl_ff[F_OTR] && !rev_done_ff
		|=> dir_ff != $past(dir_ff) && state_ff != ST_ABORT)
		else $error("first overtravel did not reverse");
	AST_OT_ABORT: assert property (@(posedge CLOCK)
		disable iff (!RESETN) ot_act && ctrl_ff[F_OTR]
		|=> state_ff == ST_ABORT ##1 !homed_ff)
		else $error("overtravel did not abort homing");
	AST_ABORT_TORQUE: assert property (@(posedge CLOCK)
		disable iff (!RESETN) state_ff == ST_ABORT |=> TORQUE_LIMIT == atq_ff)
		else $error("abort stop not under third torque limit");
	AST_FREE_TORQUE: assert property (@(posedge CLOCK)
		disable iff (!RESETN) ref_sel != REF_STOP && state_ff != ST_ABORT
		|=> TORQUE_LIMIT == TORQ_FREE)
		else $error("stopper torque used outside stopper mode");
	AST_LOAD_COORD: assert property (@(posedge CLOCK)
		disable iff (!RESETN) state_ff == ST_SETTLE && vel_zero
		|=> pos_ff == $past(coord_ff) ##1 HOME_DONE || range_ff != '0)
		else $error("completion did not load home coordinate");
	AST_DETECT_RANGE: assert property (@(posedge CLOCK)
		disable iff (!RESETN) dtime_ff <= DETECT_TIME_MAX && stq_ff <= STOP_TORQ_MAX)
		else $error("stopper setting outside its range");
endmodule
`default_nettype wire

/* File: sim/motor_plant.sv */
// Motor, encoder and sensor model standing behind the homing sequencer.
// Assumes the bench places the switch and limit windows in plant units.
`timescale 1ns/1ps
`default_nettype none
module motor_plant #(
	parameter int TH  = 500000,
	parameter int IDX = 8
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Velocity command and sensor windows
	input  wire logic signed [20:0] speed,
	input  wire logic signed [31:0] hs_lo,
	input  wire logic signed [31:0] hs_hi,
	input  wire logic signed [31:0] plim,
	input  wire logic signed [31:0] nlim,
	// Feedback and sensors
	output logic                    step,
	output logic                    fwd,
	output logic                    index,
	output logic                    home_sw,
	output logic                    plus_lim,
	output logic                    minus_lim,
	output logic signed [31:0]      pos
);
	logic signed [31:0] acc; // Fractional travel carried over
	logic signed [31:0] sum; // Travel including this cycle
	logic signed [1:0]  dir; // Step of this cycle: +1, -1 or 0
	assign sum = acc + speed;
	assign dir = (sum >= TH) ? 2'sd1 : (sum <= -TH) ? -2'sd1 : 2'sd0;
	// Sensors are plain levels of the position
	assign home_sw   = (pos >= hs_lo) && (pos <= hs_hi);
	assign plus_lim  = pos >= plim;
	assign minus_lim = pos <= nlim;
	// Integrate speed into unit steps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc   <= 0;
			pos   <= 0;
			step  <= 1'b0;
			fwd   <= 1'b0;
			index <= 1'b0;
		end else begin
			acc   <= sum - dir * TH;
			pos   <= pos + dir;
			step  <= dir != 0;
			// Direction only means something with a step; toggled otherwise
			fwd   <= (dir != 0) ? (dir > 0) : ~fwd;
			// Raw index once every IDX units of travel
			index <= (dir != 0) && ((pos + dir) % IDX == 0);
		end
	end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the homing sequencer with a motor model.
// Assumes the register map and speed units of the shared package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
	import homing_pkg::*;
	logic               clock, resetn, wr, rd, start, irq_in, busy, done, irq;
	logic [6:0]         addr;
	logic [31:0]        wdata, rdata, coord, exp_v;
	logic [31:0]        seed = 32'h0A7EE493;
	logic [8:0]         torq;
	logic signed [20:0] speed;
	logic               step, fwd, index, hsw, p_lim, n_lim;
	logic               rd_d = 1'b0;
	logic signed [31:0] hs_lo, hs_hi, plim, nlim, pos;
	int                 fail_count, num_checks;
	logic [31:0]        exp_q[$]; // Expected read data, oldest first
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Short millisecond keeps the stopper standstill counts small
	servo_homing_sequencer #(.MS_CYCLES(10)) dut (.CLOCK(clock), .RESETN(resetn),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.HOMING_START_CMD(start), .POSITIVE_TRAVEL_LIMIT(p_lim),
		.NEGATIVE_TRAVEL_LIMIT(n_lim), .HOME_LIMIT_SWITCH(hsw),
		.INTERRUPT_INPUT(irq_in), .ENCODER_INDEX(index), .POS_STEP(step),
		.POS_FWD(fwd), .SPEED_CMD(speed), .TORQUE_LIMIT(torq),
		.HOME_DONE(done), .BUSY(busy), .IRQ(irq));
	motor_plant plant (.clk(clock), .rst_n(resetn), .speed(speed), .hs_lo(hs_lo),
		.hs_hi(hs_hi), .plim(plim), .nlim(nlim), .step(step), .fwd(fwd),
		.index(index), .home_sw(hsw), .plus_lim(p_lim), .minus_lim(n_lim),
		.pos(pos));
	// Read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		if (rd_d) begin
			exp_v = exp_q.pop_front();
			`CHK("RDATA", exp_v, rdata)
		end
		rd_d <= rd;
	end
	task automatic wreg(input logic [6:0] a, input logic [31:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
	endtask
	// Note the expectation, then strobe; the monitor compares
	task automatic rreg(input logic [6:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock);
		rd   <= 1'b0;
	endtask
	task automatic results();
		$display("Checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Observed output by selector: speed, torque limit, busy
	function automatic logic [31:0] probe(input int w);
		return (w == 0) ? 32'(speed) : (w == 1) ? 32'(torq) : 32'(busy);
	endfunction
	// Bounded wait; a used-up bound ends the run
	task automatic waitfor(input int w, input logic [31:0] v);
		int n;
		n = 0;
		while (probe(w) !== v && n < 20000) begin
			@(posedge clock);
			n++;
		end
		`CHK("probe", v, probe(w))
		if (n >= 20000) results();
	endtask
	// Start rise held for two cycles, low before and after
	task automatic kick();
		@(posedge clock);
		start <= 1'b1;
		repeat (2) @(posedge clock);
		start <= 1'b0;
	endtask
	// Sensor windows relative to where the plant stands now
	task automatic place(input int hl, input int hh, input int pl);
		hs_lo <= pos + hl;
		hs_hi <= pos + hh;
		plim  <= pos + pl;
		nlim  <= pos - 1000;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	initial begin
		{resetn, wr, rd, start, irq_in} = 5'h00;
		{addr, wdata, fail_count, num_checks} = '0;
		{hs_lo, hs_hi, plim, nlim} = {4{32'sh000F4240}};
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		`CHK("TORQUE_LIMIT", 9'h12C, torq)
		rreg(A_CTRL, 32'h00000001);
		rreg(A_HSPEED, 32'h0000C350);
		rreg(A_CSPEED, 32'h00001388);
		rreg(A_ACC1, 32'h000003E8);
		rreg(A_DEC2, 32'h00001388);
		rreg(7'h34, 32'h00000000);
		wreg(A_TORQ, 32'h019000C8);
		rreg(A_TORQ, 32'h012C0064);
		wreg(A_DTIME, 32'h00004E20);
		rreg(A_DTIME, 32'h00002710);
		wreg(A_ZOFFS, 32'hFFFFFFFF);
		rreg(A_ZOFFS, 32'h000FFFFF);
		// Small offset and instant ramps keep each run short
		wreg(A_ZOFFS, 32'h00000003);
		wreg(A_ACC1, 32'h00000000);
		wreg(A_DEC1, 32'h00000000);
		wreg(A_SHIFT, 32'h00000005);
		wreg(A_MASK, 32'h00000007);
		seed = xs(seed);
		coord = seed & 32'h00007FFF;
		wreg(A_COORD, coord);
		// Plain run: switch ahead, no limit in reach
		place(20, 60, 1000);
		kick();
		waitfor(0, 32'h0000C350);
		waitfor(0, 32'h00001388);
		waitfor(2, 32'h00000000);
		repeat (3) @(posedge clock);
		`CHK("HOME_DONE", 1'b1, done)
		`CHK("IRQ", 1'b1, irq)
		rreg(A_POS, coord);
		rreg(A_STAT, 32'h00000001);
		wreg(A_STAT, 32'h00000007);
		repeat (3) @(posedge clock);
		`CHK("IRQ", 1'b0, irq)
		// Limit ahead of the switch: reverse and search back
		place(-40, -20, 30);
		kick();
		// Completion drops one edge after the start is taken
		@(posedge clock);
		`CHK("HOME_DONE", 1'b0, done)
		waitfor(0, 32'hFFFF3CB0);
		waitfor(0, 32'h00001388);
		waitfor(2, 32'h00000000);
		rreg(A_STAT, 32'h00000005);
		wreg(A_STAT, 32'h00000007);
		// Stop on limit with the third torque limit
		wreg(A_CTRL, 32'h00000801);
		wreg(A_TORQ, 32'h00960000);
		place(500, 520, 30);
		kick();
		waitfor(1, 32'h00000096);
		waitfor(2, 32'h00000000);
		rreg(A_STAT, 32'h00000002);
		repeat (4) @(posedge clock);
		`CHK("HOME_DONE", 1'b0, done)
		// Stopper reference: press torque, contact after 2 ms standstill
		wreg(A_CTRL, 32'h00000005);
		wreg(A_TORQ, 32'h00960032);
		wreg(A_DTIME, 32'h00000002);
		place(500, 520, 1000);
		kick();
		waitfor(1, 32'h00000032);
		waitfor(2, 32'h00000000);
		`CHK("HOME_DONE", 1'b1, done)
		rreg(A_STAT, 32'h00000003);
		repeat (2) @(posedge clock);
		results();
	end
endmodule
`default_nettype wire
